// ==== design/vosr_sync_det.sv ====
`timescale 1ns/1ps
`default_nettype none
module vosr_sync_det (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [7:0] sync_pins,
  output logic      [7:0] act_status,
  output logic      [7:0] pol_status
);
  import vosr_pkg::*;

  typedef struct packed {
    logic [7:0]       s1;
    logic [7:0]       s2;
    logic [7:0]       s3;
    logic [7:0]       f;
    logic [10:0]      win;
    logic [7:0]       seen;
    logic [7:0][10:0] hi;
    logic [11:0]      gap;
    logic [11:0]      prev_gap;
    logic             extra_seen;
    logic [7:0]       act;
    logic [7:0]       pol;
    logic             extra;
  } vosr_det_t;

  vosr_det_t q;
  vosr_det_t d;

  // ----------------------------------------------------------------
  // Activity, polarity and equalisation pulse measurement
  // ----------------------------------------------------------------
  // Each window flags edges and counts high time; short high time means
  // the pulses are active high. Results stand for one whole window.
  always_comb begin
    d = q;
    d.s1 = sync_pins;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.win = q.win + 11'h001;
    if (q.gap != 12'hFFF) begin
      d.gap = q.gap + 12'h001;
    end
    for (int i = 0; i < 8; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        d.f[i] = q.s2[i];
      end
      if (d.f[i] != q.f[i]) begin
        d.seen[i] = 1'b1;
      end
      if (q.f[i]) begin
        d.hi[i] = q.hi[i] + 11'h001;
      end
    end
    // Line sync 0 rising edges: a gap under half the last one is extra
    if (d.f[7] && !q.f[7]) begin
      if ((q.prev_gap != 12'h000) && (q.gap < {1'b0, q.prev_gap[11:1]})) begin
        d.extra_seen = 1'b1;
      end
      d.prev_gap = q.gap;
      d.gap = 12'h000;
    end
    if (q.win == ACT_LAST) begin
      d.win = 11'h000;
      d.act = d.seen;
      for (int i = 0; i < 8; i++) begin
        d.pol[i] = (q.hi[i] < ACT_HALF);
        d.hi[i] = 11'h000;
      end
      d.extra = d.extra_seen;
      d.seen = 8'h00;
      d.extra_seen = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Polarity layout: four syncs, coast, clamp, extra pulses, zero
  assign act_status = q.act;
  assign pol_status = {q.pol[7:4], q.pol[1:0], q.extra, 1'b0};

endmodule
`default_nettype wire

// ==== design/vosr_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Bandwidth bit low selects low analog bandwidth, high selects high; resets 1.
// - Source bit picks register or pin power-down; pin polarity bit sets level.
// - Manual mode: power-down bit 1 powers down, 0 runs; resets 0.
// - Fast switching keeps chip powered but floats outputs on power-down.
// - During power-down, slicer pin floats only if its control bit is 1.
// - Output mode 100 4:4:4, 101 4:2:2, 110 4:4:4 DDR; resets 100.
// - Primary port driven when its enable is 1, floated otherwise; resets 1.
// - Secondary port driven when its enable is 1, floated otherwise; resets 0.
// - Two-bit drive strength for all outputs except vertical sync; resets 10.
// - Clock invert bit inverts whatever leaves on the pixel clock pin.
// - Clock select: pixel, 90 degree, double pixel, internal 40 MHz.
// - Global high-impedance bit floats every output but the slicer pin.
// - Slicer high-impedance bit floats the slicer pin.
// - Field polarity 0: even low, odd high; 1 reverses it.
// - PLL fed raw sync when bit 0, filtered sync when 1; resets 1.
// - Sync processor takes raw sync at 0, regenerated sync at 1; resets 0.
// - Filter passes sync only within a window, 25 ns steps, resets 0x0A.
// - Detect register shows activity of eight sync, coast and clamp inputs.
// - Polarity register shows detected polarity of six inputs, 1 high.
// - Polarity bit 1 flags extraneous or equalisation pulses on line sync 0.
// - All registers are reached over the two-wire serial control port.
module vosr_top (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       scl_pin,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       pd_pin,
  input  wire logic       line_sync_input_0,
  input  wire logic       line_sync_input_1,
  input  wire logic       frame_sync_input_0,
  input  wire logic       frame_sync_input_1,
  input  wire logic       green_sync_input_0,
  input  wire logic       green_sync_input_1,
  input  wire logic       ext_coast_input,
  input  wire logic       ext_clamp_input,
  input  wire logic       field_odd,
  input  wire logic       raw_sync,
  input  wire logic       regen_hsync,
  input  wire logic       pix_clk,
  input  wire logic       pix_clk_90,
  input  wire logic       pix_clk_2x,
  input  wire logic       int_clk_40,
  output logic            analog_bw_high,
  output logic            power_down,
  output logic [2:0]      output_mode,
  output logic [1:0]      drive_strength,
  output logic            primary_port_oe,
  output logic            secondary_port_oe,
  output logic            ctrl_pins_oe,
  output logic            sync_slicer_oe,
  output logic            field_out_pin,
  output logic            pixel_clock_out_pin,
  output logic            pll_sync_in,
  output logic            sync_proc_in
);
  import vosr_pkg::*;

  typedef struct packed {
    logic [2:0]  scl_s;
    logic [2:0]  sda_s;
    logic [2:0]  pd_s;
    logic        scl_f;
    logic        sda_f;
    logic        pd_f;
    vosr_st_t    st;
    logic [3:0]  cnt;
    logic [7:0]  shreg;
    logic [7:0]  sub;
    logic        rw;
    logic        nack;
    logic        sda_oe;
    logic [7:0]  pwr;
    logic [7:0]  os1;
    logic [7:0]  os2;
    logic [7:0]  rsva;
    logic [7:0]  rsvb;
    logic [7:0]  win;
    logic        pd_q;
    logic        pri_oe;
    logic        sec_oe;
    logic        ctl_oe;
    logic        sog_oe;
    logic        field;
    logic        pll_src;
    logic        sp_src;
    logic        regen_prev;
    logic [11:0] per_cnt;
    logic [11:0] period;
  } vosr_top_t;

  vosr_top_t  q;
  vosr_top_t  d;
  logic [7:0] act_status;
  logic [7:0] pol_status;
  logic       scl_rise;
  logic       scl_fall;
  logic       bus_start;
  logic       bus_stop;
  logic       pin_act;
  logic       pd_req;
  logic       hiz_all;
  logic       filt;
  logic [11:0] half;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Register read decode; unmapped addresses read as zero
  function automatic logic [7:0] rd_reg(input logic [7:0] a, input vosr_top_t s,
                                        input logic [7:0] act, input logic [7:0] pol);
    logic [7:0] r;
    r = 8'h00;
    unique case (a)
      ADR_PWR:   r = s.pwr;
      ADR_OSEL1: r = s.os1;
      ADR_OSEL2: r = s.os2;
      ADR_RSVA:  r = s.rsva;
      ADR_RSVB:  r = s.rsvb;
      ADR_WIN:   r = s.win;
      ADR_ACT:   r = act;
      ADR_POL:   r = pol;
      default:   r = 8'h00;
    endcase
    return r;
  endfunction

  // Half the filter window in clock cycles, rounded down
  function automatic logic [11:0] win_half(input logic [7:0] w);
    logic [19:0] t;
    t = 20'({12'h000, w} * 20'(WIN_STEP_NS)) / 20'(2 * CLK_NS);
    return t[11:0];
  endfunction

  // ----------------------------------------------------------------
  // Sync status detection
  // ----------------------------------------------------------------
  vosr_sync_det vosr_sync_det_i (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .sync_pins  ({line_sync_input_0, line_sync_input_1, frame_sync_input_0,
                  frame_sync_input_1, green_sync_input_0, green_sync_input_1,
                  ext_coast_input, ext_clamp_input}),
    .act_status (act_status),
    .pol_status (pol_status)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    // Pin synchronisers; a level is taken once stages two and three agree
    d.scl_s = {q.scl_s[1:0], scl_pin};
    d.sda_s = {q.sda_s[1:0], sda_in};
    d.pd_s  = {q.pd_s[1:0], pd_pin};
    if (q.scl_s[1] == q.scl_s[2]) begin
      d.scl_f = q.scl_s[1];
    end
    if (q.sda_s[1] == q.sda_s[2]) begin
      d.sda_f = q.sda_s[1];
    end
    if (q.pd_s[1] == q.pd_s[2]) begin
      d.pd_f = q.pd_s[1];
    end
    scl_rise  = d.scl_f && !q.scl_f;
    scl_fall  = !d.scl_f && q.scl_f;
    bus_start = q.scl_f && d.scl_f && q.sda_f && !d.sda_f;
    bus_stop  = q.scl_f && d.scl_f && !q.sda_f && d.sda_f;

    // Serial slave: address, sub-address, then data with auto increment
    if (bus_start) begin
      d.st = ST_ADDR;
      d.cnt = 4'h0;
      d.sda_oe = 1'b0;
    end else if (bus_stop) begin
      d.st = ST_IDLE;
      d.sda_oe = 1'b0;
    end else if (scl_rise) begin
      if (q.st == ST_RACK) begin
        d.nack = q.sda_f;
      end else if (q.st != ST_IDLE && q.cnt != 4'h8) begin
        d.cnt = q.cnt + 4'h1;
        if (q.st != ST_RD) begin
          d.shreg = {q.shreg[6:0], d.sda_f};
        end
      end
    end else if (scl_fall) begin
      unique case (q.st)
        ST_IDLE: begin
          d.sda_oe = 1'b0;
        end
        ST_ADDR: begin
          if (q.cnt == 4'h8) begin
            if (q.shreg[7:1] == DEV_ADDR) begin
              d.st = ST_AACK;
              d.rw = q.shreg[0];
              d.sda_oe = 1'b1;
            end else begin
              d.st = ST_IDLE;
            end
          end
        end
        ST_AACK: begin
          d.cnt = 4'h0;
          if (q.rw) begin
            d.st = ST_RD;
            d.shreg = rd_reg(q.sub, q, act_status, pol_status);
            d.sub = q.sub + 8'h01;
            d.sda_oe = !d.shreg[7];
          end else begin
            d.st = ST_SUB;
            d.sda_oe = 1'b0;
          end
        end
        ST_SUB: begin
          if (q.cnt == 4'h8) begin
            d.st = ST_SACK;
            d.sub = q.shreg;
            d.sda_oe = 1'b1;
          end
        end
        ST_SACK, ST_WACK: begin
          d.st = ST_WR;
          d.cnt = 4'h0;
          d.sda_oe = 1'b0;
        end
        ST_WR: begin
          if (q.cnt == 4'h8) begin
            d.st = ST_WACK;
            d.sda_oe = 1'b1;
            d.sub = q.sub + 8'h01;
            // Status registers are not writable and ignore the byte
            unique case (q.sub)
              ADR_PWR:   d.pwr = q.shreg;
              ADR_OSEL1: d.os1 = q.shreg;
              ADR_OSEL2: d.os2 = q.shreg;
              ADR_RSVA:  d.rsva = q.shreg;
              ADR_RSVB:  d.rsvb = q.shreg;
              ADR_WIN:   d.win = q.shreg;
              default:   d.pwr = q.pwr;
            endcase
          end
        end
        ST_RD: begin
          if (q.cnt == 4'h8) begin
            d.st = ST_RACK;
            d.sda_oe = 1'b0;
          end else begin
            d.shreg = {q.shreg[6:0], 1'b0};
            d.sda_oe = !q.shreg[6];
          end
        end
        ST_RACK: begin
          if (q.nack) begin
            d.st = ST_IDLE; // Master ends the read
          end else begin
            d.st = ST_RD;
            d.cnt = 4'h0;
            d.shreg = rd_reg(q.sub, q, act_status, pol_status);
            d.sub = q.sub + 8'h01;
            d.sda_oe = !d.shreg[7];
          end
        end
        default: begin
          d.st = ST_IDLE;
          d.sda_oe = 1'b0;
        end
      endcase
    end

    // Power-down request from register or from the pin
    pin_act = q.pd_f ^ !q.pwr[PWR_POL];
    pd_req  = q.pwr[PWR_SRC] ? pin_act : q.pwr[PWR_DOWN];
    d.pd_q  = pd_req && !q.pwr[PWR_FAST];

    // Output enables; a powered-down chip floats its outputs as well
    hiz_all  = q.os2[OS2_ALLZ] || pd_req;
    d.pri_oe = q.os1[OS1_PRI] && !hiz_all;
    d.sec_oe = q.os1[OS1_SEC] && !hiz_all;
    d.ctl_oe = !hiz_all;
    d.sog_oe = !(q.os2[OS2_SOGZ] || (pd_req && q.pwr[PWR_SOGZ]));
    d.field  = field_odd ^ q.os2[OS2_FPOL];

    // Sync filter: open around the expected and the last regenerated edge.
    // The expected position is the last line period, so a lost line
    // costs one period of filtered sync until the period is relearnt.
    d.regen_prev = regen_hsync;
    if (q.per_cnt != 12'hFFF) begin
      d.per_cnt = q.per_cnt + 12'h001;
    end
    if (regen_hsync && !q.regen_prev) begin
      d.period = q.per_cnt;
      d.per_cnt = 12'h000;
    end
    half = win_half(q.win);
    filt = raw_sync && ((q.per_cnt <= half) ||
           ({1'b0, q.per_cnt} + {1'b0, half} >= {1'b0, q.period}));
    d.pll_src = q.os2[OS2_PLLF] ? filt : raw_sync;
    d.sp_src  = q.os2[OS2_SPSEL] ? regen_hsync : raw_sync;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q      <= '0;
      q.st   <= ST_IDLE;
      q.scl_s <= 3'h7; // Idle bus is high
      q.sda_s <= 3'h7;
      q.pd_s  <= 3'h7; // Reset polarity is active low, so the idle pin is high
      q.pd_f  <= 1'b1; // A zero here would fake a power-down until the pin settles
      q.scl_f <= 1'b1;
      q.sda_f <= 1'b1;
      q.pwr  <= RST_PWR;
      q.os1  <= RST_OSEL1;
      q.os2  <= RST_OSEL2;
      q.rsva <= RST_RSVA;
      q.rsvb <= RST_RSVB;
      q.win  <= RST_WIN;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Open-drain data line: only ever pulls low
  assign sda_out           = 1'b0;
  assign sda_oe            = q.sda_oe;
  assign analog_bw_high    = q.pwr[PWR_BW];
  assign power_down        = q.pd_q;
  assign output_mode       = q.os1[OS1_MODE_LSB +: 3];
  assign drive_strength    = q.os1[OS1_DRV_LSB +: 2];
  assign primary_port_oe   = q.pri_oe;
  assign secondary_port_oe = q.sec_oe;
  assign ctrl_pins_oe      = q.ctl_oe;
  assign sync_slicer_oe    = q.sog_oe;
  assign field_out_pin     = q.field;
  assign pll_sync_in       = q.pll_src;
  assign sync_proc_in      = q.sp_src;

  // Clock path is a pure mux; a register here would halve the rate
  always_comb begin
    unique case (q.os2[OS2_CKSEL_LSB +: 2])
      CKSEL_PIX:   pixel_clock_out_pin = pix_clk    ^ q.os1[OS1_CKINV];
      CKSEL_PIX90: pixel_clock_out_pin = pix_clk_90 ^ q.os1[OS1_CKINV];
      CKSEL_PIX2X: pixel_clock_out_pin = pix_clk_2x ^ q.os1[OS1_CKINV];
      CKSEL_INT40: pixel_clock_out_pin = int_clk_40 ^ q.os1[OS1_CKINV];
    endcase
  end

endmodule
`default_nettype wire

// ==== inc/vosr_pkg.sv ====
`default_nettype none
package vosr_pkg;

  // ----------------------------------------------------------------
  // Serial port and register map
  // ----------------------------------------------------------------
  localparam logic [6:0] DEV_ADDR   = 7'h4C; // Arbitrary bus address
  localparam logic [7:0] ADR_PWR    = 8'h1E;
  localparam logic [7:0] ADR_OSEL1  = 8'h1F;
  localparam logic [7:0] ADR_OSEL2  = 8'h20;
  localparam logic [7:0] ADR_RSVA   = 8'h21;
  localparam logic [7:0] ADR_RSVB   = 8'h22;
  localparam logic [7:0] ADR_WIN    = 8'h23;
  localparam logic [7:0] ADR_ACT    = 8'h24;
  localparam logic [7:0] ADR_POL    = 8'h25;

  // Values after reset
  localparam logic [7:0] RST_PWR    = 8'h30;
  localparam logic [7:0] RST_OSEL1  = 8'h94;
  localparam logic [7:0] RST_OSEL2  = 8'h04;
  localparam logic [7:0] RST_RSVA   = 8'h20;
  localparam logic [7:0] RST_RSVB   = 8'h32;
  localparam logic [7:0] RST_WIN    = 8'h0A;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PWR_BW        = 5;
  localparam int PWR_SRC       = 4;
  localparam int PWR_DOWN      = 3;
  localparam int PWR_POL       = 2;
  localparam int PWR_FAST      = 1;
  localparam int PWR_SOGZ      = 0;
  localparam int OS1_MODE_LSB  = 5;
  localparam int OS1_PRI       = 4;
  localparam int OS1_SEC       = 3;
  localparam int OS1_DRV_LSB   = 1;
  localparam int OS1_CKINV     = 0;
  localparam int OS2_CKSEL_LSB = 6;
  localparam int OS2_ALLZ      = 5;
  localparam int OS2_SOGZ      = 4;
  localparam int OS2_FPOL      = 3;
  localparam int OS2_PLLF      = 2;
  localparam int OS2_SPSEL     = 1;

  // Output mode and clock select encodings
  localparam logic [2:0] MODE_444     = 3'h4;
  localparam logic [2:0] MODE_422     = 3'h5;
  localparam logic [2:0] MODE_444_DDR = 3'h6;
  localparam logic [1:0] CKSEL_PIX    = 2'h0;
  localparam logic [1:0] CKSEL_PIX90  = 2'h1;
  localparam logic [1:0] CKSEL_PIX2X  = 2'h2;
  localparam logic [1:0] CKSEL_INT40  = 2'h3;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS       = 50;
  localparam int WIN_STEP_NS  = 25;
  localparam int ACT_WIN_NS   = 100000;
  localparam int ACT_WIN_CYC  = ACT_WIN_NS / CLK_NS;
  localparam logic [10:0] ACT_LAST = 11'(ACT_WIN_CYC - 1);
  localparam logic [10:0] ACT_HALF = 11'(ACT_WIN_CYC / 2);

  // Serial port states, Gray coded along the usual path
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_ADDR = 4'h1, ST_AACK = 4'h3, ST_SUB  = 4'h2,
    ST_SACK = 4'h6, ST_WR   = 4'h7, ST_WACK = 4'h5, ST_RD   = 4'h4,
    ST_RACK = 4'hC
  } vosr_st_t;

endpackage
`default_nettype wire

// ==== verif/vosr_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module vosr_checker
  import vosr_pkg::*;
(
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       sda_out,
  input wire logic       field_odd,
  input wire logic       raw_sync,
  input wire logic       regen_hsync,
  input wire logic       pix_clk,
  input wire logic       pix_clk_90,
  input wire logic       pix_clk_2x,
  input wire logic       int_clk_40,
  input wire logic       analog_bw_high,
  input wire logic       power_down,
  input wire logic [2:0] output_mode,
  input wire logic [1:0] drive_strength,
  input wire logic       primary_port_oe,
  input wire logic       secondary_port_oe,
  input wire logic       ctrl_pins_oe,
  input wire logic       field_out_pin,
  input wire logic       pixel_clock_out_pin,
  input wire logic       sync_proc_in
);
  logic [1:0] age_q;
  logic [3:0] ck;
  logic       settled;

  // Derived outputs are only trusted a few edges after reset
  always_ff @(posedge clk) age_q <= sys_rst ? 2'h0 : age_q + 2'(age_q != 2'h3);
  assign settled = age_q == 2'h3;
  assign ck = {pix_clk, pix_clk_90, pix_clk_2x, int_clk_40};

  // --------------------
  // Checks
  // --------------------
  a_reset_mode: assert property (@(posedge clk) sys_rst |=> output_mode == MODE_444)
    else $error("output mode wrong after reset");
  a_reset_drive: assert property (@(posedge clk) sys_rst |=> drive_strength == 2'h2)
    else $error("drive strength wrong after reset");
  a_reset_bw: assert property (@(posedge clk) sys_rst |=> analog_bw_high)
    else $error("bandwidth not high after reset");
  a_sda_open_drain: assert property (@(posedge clk) disable iff (sys_rst) !sda_out)
    else $error("serial data driven high");
  a_pd_floats: assert property (@(posedge clk) disable iff (sys_rst)
    power_down |-> !primary_port_oe && !secondary_port_oe && !ctrl_pins_oe)
    else $error("outputs driven in power-down");
  a_field_follow: assert property (@(posedge clk) disable iff (sys_rst)
    settled && $changed(field_odd) |=> $changed(field_out_pin))
    else $error("field output did not follow field");
  a_proc_raw_path: assert property (@(posedge clk) disable iff (sys_rst)
    settled && (raw_sync == regen_hsync) [*2] |-> sync_proc_in == $past(raw_sync))
    else $error("sync processor input wrong");
  a_clk_path: assert property (@(posedge clk) disable iff (sys_rst)
    ck == 4'hF && $past(ck) == 4'h0 |-> $changed(pixel_clock_out_pin))
    else $error("pixel clock output did not toggle");
endmodule

bind vosr_top vosr_checker vosr_checker_i (
  .clk, .sys_rst, .sda_out, .field_odd, .raw_sync, .regen_hsync, .pix_clk, .pix_clk_90,
  .pix_clk_2x, .int_clk_40, .analog_bw_high, .power_down, .output_mode, .drive_strength,
  .primary_port_oe, .secondary_port_oe, .ctrl_pins_oe, .field_out_pin,
  .pixel_clock_out_pin, .sync_proc_in
);
`default_nettype wire

// ==== verif/vosr_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module vosr_top_tb;
  import vosr_pkg::*;
  logic       clk, sys_rst, scl_pin, m_sda, pd_pin, field_odd, raw_sync, regen_hsync, a;
  logic [7:0] sp, d0, d1;
  logic [3:0] ck;
  wire logic  sda_in, pix_clk, pix_clk_90, pix_clk_2x, int_clk_40;
  wire logic  line_sync_input_0, line_sync_input_1, frame_sync_input_0, frame_sync_input_1;
  wire logic  green_sync_input_0, green_sync_input_1, ext_coast_input, ext_clamp_input;
  logic       sda_out, sda_oe, analog_bw_high, power_down, primary_port_oe, secondary_port_oe;
  logic       ctrl_pins_oe, sync_slicer_oe, field_out_pin, pixel_clock_out_pin;
  logic       pll_sync_in, sync_proc_in;
  logic [2:0] output_mode;
  logic [1:0] drive_strength;
  int         miscompares, cmp_count;
  // Tables: reset bytes; {power value, pin, bw/pd/primary/slicer}; {value, expect, mask}
  logic [7:0]  rst_tab [6] = '{8'h30, 8'h94, 8'h04, 8'h20, 8'h32, 8'h0A};
  logic [12:0] pd_tab [5] = '{13'h051D, 13'h0578, 13'h0205, 13'h0295, 13'h0283};
  logic [19:0] os_tab [4] = '{20'h2B27F, 20'h55DBE, 20'h9753E, 20'hC9EFF};

  // The data wire is open drain, so either party may pull it low
  assign sda_in = m_sda & ~sda_oe;
  assign {pix_clk, pix_clk_90, pix_clk_2x, int_clk_40} = ck;
  assign {line_sync_input_0, line_sync_input_1, frame_sync_input_0, frame_sync_input_1,
          green_sync_input_0, green_sync_input_1, ext_coast_input, ext_clamp_input} = sp;

  vosr_top vosr_top_i (
    .clk, .sys_rst, .scl_pin, .sda_in, .sda_out, .sda_oe, .pd_pin, .line_sync_input_0,
    .line_sync_input_1, .frame_sync_input_0, .frame_sync_input_1, .green_sync_input_0,
    .green_sync_input_1, .ext_coast_input, .ext_clamp_input, .field_odd, .raw_sync,
    .regen_hsync, .pix_clk, .pix_clk_90, .pix_clk_2x, .int_clk_40, .analog_bw_high,
    .power_down, .output_mode, .drive_strength, .primary_port_oe, .secondary_port_oe,
    .ctrl_pins_oe, .sync_slicer_oe, .field_out_pin, .pixel_clock_out_pin, .pll_sync_in,
    .sync_proc_in
  );

  // 20 MHz system clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // --------------------
  // Tasks
  // --------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    if (miscompares == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Eight cycles per phase keeps well above the pin filter latency
  task automatic hw;
    repeat (8) @(posedge clk);
  endtask

  task automatic bit_io(input logic b, output logic r);
    m_sda <= b;
    hw;
    scl_pin <= 1'b1;
    hw;
    r = sda_in;
    scl_pin <= 1'b0;
    hw;
  endtask

  task automatic byte_io(input logic [7:0] b, input logic m_ack, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) bit_io(b[i], r[i]);
    bit_io(m_ack, a);
  endtask

  task automatic start;
    m_sda <= 1'b1;
    hw;
    scl_pin <= 1'b1;
    hw;
    m_sda <= 1'b0;
    hw;
    scl_pin <= 1'b0;
    hw;
  endtask

  task automatic stop;
    m_sda <= 1'b0;
    hw;
    scl_pin <= 1'b1;
    hw;
    m_sda <= 1'b1;
    hw;
  endtask

  task automatic head(input logic [7:0] adr);
    start;
    byte_io({DEV_ADDR, 1'b0}, 1'b1, d0);
    check({7'h0, a}, 8'h00, "address ack");
    byte_io(adr, 1'b1, d0);
  endtask

  task automatic reg_wr(input logic [7:0] adr, input logic [7:0] dat);
    head(adr);
    byte_io(dat, 1'b1, d0);
    stop;
  endtask

  // Reads two bytes in a row, so auto-increment is exercised every time
  task automatic reg_rd(input logic [7:0] adr);
    head(adr);
    start;
    byte_io({DEV_ADDR, 1'b1}, 1'b1, d0);
    byte_io(8'hFF, 1'b0, d0);
    byte_io(8'hFF, 1'b1, d1);
    stop;
  endtask

  task automatic pulse(input int gap);
    sp <= 8'hFF;
    repeat (10) @(posedge clk);
    sp <= 8'h00;
    repeat (gap - 10) @(posedge clk);
  endtask

  // --------------------
  // Tests
  // --------------------
  initial begin
    {sys_rst, scl_pin, m_sda, pd_pin} = 4'hF;
    {field_odd, raw_sync, regen_hsync} = 3'h0;
    sp = 8'h00;
    ck = 4'h0;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    check({analog_bw_high, primary_port_oe, secondary_port_oe, output_mode, drive_strength},
          8'hD2, "port reset state");
    for (int i = 0; i < 3; i++) begin
      reg_rd(ADR_PWR + 8'(2 * i));
      check(d0, rst_tab[2 * i], "reset byte");
      check(d1, rst_tab[2 * i + 1], "reset byte");
    end
    reg_wr(ADR_OSEL2, 8'h05);
    for (int i = 0; i < 4; i++) begin
      reg_wr(ADR_OSEL1, {3'(4 + i % 3), 2'b11, 2'(i), 1'b0});
      check({2'h0, secondary_port_oe, output_mode, drive_strength},
            {2'h0, 1'b1, 3'(4 + i % 3), 2'(i)}, "format");
    end
    reg_wr(ADR_ACT, 8'hFF);
    reg_rd(ADR_ACT);
    check(d0, 8'h00, "status after write");
    reg_rd(8'h3F);
    check(d0, 8'h00, "unmapped read");
    repeat (50) pulse(100);
    reg_rd(ADR_ACT);
    check(d0, 8'hFF, "activity");
    check(d1, 8'hFC, "polarity");
    repeat (40) begin
      pulse(100);
      pulse(30);
    end
    reg_rd(ADR_ACT);
    check(d1, 8'hFE, "extra pulses");
    for (int i = 0; i < 5; i++) begin
      reg_wr(ADR_PWR, pd_tab[i][12:5]);
      pd_pin <= pd_tab[i][4];
      repeat (10) @(posedge clk);
      check({4'h0, analog_bw_high, power_down, primary_port_oe, sync_slicer_oe},
            {4'h0, pd_tab[i][3:0]}, "power");
    end
    {field_odd, raw_sync, regen_hsync, ck} <= {3'b110, 4'b0101};
    for (int i = 0; i < 4; i++) begin
      reg_wr(ADR_OSEL2, os_tab[i][19:12]);
      check({2'h0, os_tab[i][5:0] & {pixel_clock_out_pin, ctrl_pins_oe, sync_slicer_oe,
             field_out_pin, sync_proc_in, pll_sync_in}}, {2'h0, os_tab[i][11:6]},
            "routing");
    end
    reg_wr(ADR_OSEL1, 8'h9F);
    check({7'h0, pixel_clock_out_pin}, 8'h00, "clock invert");
    ck <= 4'h0;
    repeat (2) @(posedge clk);
    ck <= 4'hF;
    field_odd <= 1'b0;
    repeat (2) @(posedge clk);
    // Filtered sync with raw sync held high: open just after each regenerated
    // edge, shut in mid-line once the line period is known
    reg_wr(ADR_OSEL2, 8'h05);
    repeat (3) begin
      regen_hsync <= 1'b1;
      repeat (3) @(posedge clk);
      check({7'h0, pll_sync_in}, 8'h01, "filter open");
      regen_hsync <= 1'b0;
      repeat (17) @(posedge clk);
      check({7'h0, pll_sync_in}, 8'h00, "filter shut");
      repeat (20) @(posedge clk);
    end
    start;
    byte_io({~DEV_ADDR, 1'b0}, 1'b1, d0);
    check({7'h0, a}, 8'h01, "foreign address");
    stop;
    tally_and_finish;
  end

  // Watchdog: the run needs roughly 31000 cycles
  initial begin
    repeat (80000) @(posedge clk);
    miscompares++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
